// ===== common/ecr_pkg.sv
// Overview of operation
// - resync path synchronises generator into channel clock
// - resync channels raise flags and update status
// - sync and resync channels request clock per event, or always when always-on set
// - edge detect: rising, falling or both edges
// - pending bit high until users handle event
// - users-ready bit high when all users ready
// - software event bit injects event on selected channel
// - irq high while flag and enable both set
// - enable-set writes enable, enable-clear writes disable
// - all sources share one interrupt line
// - overrun when users busy or event pending
// - no overrun flag on asynchronous path
// - event-detected flag set on every detected event
// - no event-detected flag on asynchronous path
// - interrupt can wake device from sleep
// - edge codes: none, rising, falling, both
// - path codes: sync, resync, async, reserved
// - soft reset clears all but synchroniser stages and read data, discards other bits
// - byte write of select, then read config
package ecr_pkg;

  // ==========================================================
  // sizes and timing
  localparam int ECR_NUM_CH = 6;
  localparam int ECR_GEN_W = 6;
  localparam int ECR_ADDR_W = 8;
  localparam int ECR_SYNC_STAGES = 2;

  // ==========================================================
  // register offsets
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_CTRL = 8'h00;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_CHAN = 8'h04;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_USER = 8'h08;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_STATE = 8'h0C;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_ENCLR = 8'h10;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_ENSET = 8'h14;
  localparam logic [ECR_ADDR_W-1:0] ECR_OFS_FLAGS = 8'h18;

  // ==========================================================
  // field positions
  localparam int ECR_CTRL_SRST_BIT = 0;
  localparam int ECR_CTRL_AON_BIT = 4;
  localparam int ECR_CH_SEL_LSB = 0;
  localparam int ECR_CH_SEL_W = 3;
  localparam int ECR_CH_SOFTWARE_EVENT_TRIGGER_BIT = 8;
  localparam int ECR_CH_GEN_LSB = 16;
  localparam int ECR_CH_PATH_LSB = 24;
  localparam int ECR_CH_EDGE_LSB = 26;
  localparam int ECR_USER_USR_LSB = 0;
  localparam int ECR_USER_USR_W = 5;
  localparam int ECR_USER_CH_LSB = 8;
  localparam int ECR_USER_CH_W = 4;
  localparam int ECR_LO_LSB = 0;
  localparam int ECR_HI_LSB = 8;

  // ==========================================================
  // encodings and reset values
  localparam logic [1:0] ECR_EDGE_NONE = 2'h0;
  localparam logic [1:0] ECR_EDGE_RISE = 2'h1;
  localparam logic [1:0] ECR_EDGE_FALL = 2'h2;
  localparam logic [1:0] ECR_EDGE_BOTH = 2'h3;
  localparam logic [1:0] ECR_PATH_SYNC = 2'h0;
  localparam logic [1:0] ECR_PATH_RESYNC = 2'h1;
  localparam logic [1:0] ECR_PATH_ASYNC = 2'h2;
  localparam logic [15:0] ECR_USER_RST = 16'h0000;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] path;
    logic [ECR_GEN_W-1:0] gen_sel;
  } ecr_chcfg_s;

  typedef struct packed {
    logic evt;
    logic pending;
    logic users_ready;
    logic detect;
    logic overrun;
    logic clk_req;
  } ecr_chout_s;

  localparam ecr_chcfg_s ECR_CHCFG_RST = '0;

endpackage : ecr_pkg

// ===== verilog/ecr_sync.sv
`timescale 1ns/10ps
module ecr_sync
  import ecr_pkg::*;
#(
  parameter int STAGES = ECR_SYNC_STAGES
)(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // level
  input wire logic async_in,
  output logic sync_out
);

  logic [STAGES-1:0] stage_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule : ecr_sync

// ===== verilog/ecr_channel.sv
`timescale 1ns/10ps
module ecr_channel
  import ecr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic soft_rst_in,
  // configuration
  input wire ecr_chcfg_s cfg_in,
  input wire logic always_on_in,
  // event sources
  input wire logic gen_raw_in,
  input wire logic gen_resync_in,
  input wire logic sw_evt_in,
  // user handshake
  input wire logic users_ready_in,
  input wire logic users_done_in,
  // results
  output ecr_chout_s stat_out
);

  logic on_path;
  logic level;
  logic level_q;
  logic edge_hit;
  logic det;
  logic pending_q;
  logic event_q;

  assign on_path = (cfg_in.path == ECR_PATH_SYNC) || (cfg_in.path == ECR_PATH_RESYNC);
  assign level = (cfg_in.path == ECR_PATH_RESYNC) ? gen_resync_in : gen_raw_in;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_q <= 1'b0;
    end else if (soft_rst_in) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  always_comb begin
    unique case (cfg_in.edge_sel)
      ECR_EDGE_NONE: edge_hit = 1'b0;
      ECR_EDGE_RISE: edge_hit = level && !level_q;
      ECR_EDGE_FALL: edge_hit = !level && level_q;
      ECR_EDGE_BOTH: edge_hit = level ^ level_q;
    endcase
  end

  // software event bypasses edge detector but not the path check
  assign det = on_path && (edge_hit || sw_evt_in);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending_q <= 1'b0;
    end else if (soft_rst_in) begin
      pending_q <= 1'b0;
    end else if (det) begin
      pending_q <= 1'b1;
    end else if (users_done_in) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_q <= 1'b0;
    end else begin
      event_q <= det && !soft_rst_in;
    end
  end

  // async path passes the generator straight through
  assign stat_out.evt = (cfg_in.path == ECR_PATH_ASYNC) ? gen_raw_in : event_q;
  assign stat_out.pending = pending_q && on_path;
  assign stat_out.users_ready = users_ready_in && on_path;
  assign stat_out.detect = det;
  assign stat_out.overrun = det && (!users_ready_in || pending_q);
  assign stat_out.clk_req = on_path && (always_on_in || pending_q || det || event_q);

  chk_async_quiet: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (cfg_in.path == ECR_PATH_ASYNC) |-> !stat_out.detect && !stat_out.overrun)
    else $error("flag source active on async path");
  chk_rise_detect: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (cfg_in.path == ECR_PATH_SYNC) && (cfg_in.edge_sel == ECR_EDGE_RISE) && $stable(cfg_in)
    && $rose(gen_raw_in) && !soft_rst_in |=> stat_out.evt && pending_q)
    else $error("rising edge not propagated");
  chk_resync_route: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (cfg_in.path == ECR_PATH_RESYNC) && (cfg_in.edge_sel == ECR_EDGE_FALL) && $stable(cfg_in)
    && $fell(gen_resync_in) |-> stat_out.detect)
    else $error("resync falling edge missed");
  chk_pending_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    pending_q && !users_done_in && !soft_rst_in |=> pending_q)
    else $error("pending dropped before users done");
  chk_clock_request: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    on_path && !always_on_in && !pending_q && !det && !event_q |-> !stat_out.clk_req)
    else $error("clock requested with nothing to carry");

endmodule : ecr_channel

// ===== verilog/ecr_router.sv
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module ecr_router
  import ecr_pkg::*;
#(
  parameter int NUM_CH = ECR_NUM_CH
)(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ECR_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // event generators, index zero means none
  input wire logic [(1<<ECR_GEN_W)-1:0] gen_events_in,
  // event users
  input wire logic [NUM_CH-1:0] users_ready_in,
  input wire logic [NUM_CH-1:0] users_done_in,
  output logic [NUM_CH-1:0] chan_event_out,
  // clock requests and interrupt
  output logic [NUM_CH-1:0] chan_clk_req_out,
  output logic irq_out
);

  localparam int FL_W = 2 * NUM_CH;

  // ==========================================================
  // bus decode
  logic wr_en;
  logic rd_setup;
  logic hit_ctrl;
  logic hit_chan;
  logic hit_user;
  logic hit_state;
  logic hit_enclr;
  logic hit_enset;
  logic hit_flags;
  logic mapped;
  logic srst_w;
  logic ch_wr;
  logic ch_full;
  logic [ECR_CH_SEL_W-1:0] wr_sel;
  ecr_chcfg_s wr_cfg;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign hit_ctrl = (paddr_in == ECR_OFS_CTRL);
  assign hit_chan = (paddr_in == ECR_OFS_CHAN);
  assign hit_user = (paddr_in == ECR_OFS_USER);
  assign hit_state = (paddr_in == ECR_OFS_STATE);
  assign hit_enclr = (paddr_in == ECR_OFS_ENCLR);
  assign hit_enset = (paddr_in == ECR_OFS_ENSET);
  assign hit_flags = (paddr_in == ECR_OFS_FLAGS);
  assign mapped = hit_ctrl || hit_chan || hit_user || hit_state || hit_enclr || hit_enset || hit_flags;

  // soft reset wins over every other bit of the same write
  assign srst_w = wr_en && hit_ctrl && pstrb_in[0] && pwdata_in[ECR_CTRL_SRST_BIT];
  assign ch_wr = wr_en && hit_chan && pstrb_in[0];
  assign ch_full = (pstrb_in == 4'hF);
  assign wr_sel = pwdata_in[ECR_CH_SEL_LSB +: ECR_CH_SEL_W];
  assign wr_cfg.edge_sel = pwdata_in[ECR_CH_EDGE_LSB +: 2];
  assign wr_cfg.path = pwdata_in[ECR_CH_PATH_LSB +: 2];
  assign wr_cfg.gen_sel = pwdata_in[ECR_CH_GEN_LSB +: ECR_GEN_W];

  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  // ==========================================================
  // pair-vector helpers: overrun or ready in low byte, detect or pending in next byte
  function automatic logic [31:0] pack_pair(input logic [FL_W-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ECR_LO_LSB +: NUM_CH] = v[NUM_CH-1:0];
    w[ECR_HI_LSB +: NUM_CH] = v[FL_W-1:NUM_CH];
    return w;
  endfunction : pack_pair

  logic [FL_W-1:0] wmask;

  assign wmask = {pwdata_in[ECR_HI_LSB +: NUM_CH] & {NUM_CH{pstrb_in[1]}},
                  pwdata_in[ECR_LO_LSB +: NUM_CH] & {NUM_CH{pstrb_in[0]}}};

  // ==========================================================
  // control register
  logic always_on_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      always_on_q <= 1'b0;
    end else if (srst_w) begin
      always_on_q <= 1'b0;
    end else if (wr_en && hit_ctrl && pstrb_in[0]) begin
      always_on_q <= pwdata_in[ECR_CTRL_AON_BIT];
    end
  end

  // ==========================================================
  // channel configuration
  logic [ECR_CH_SEL_W-1:0] sel_q;
  ecr_chcfg_s cfg_q [NUM_CH];
  ecr_chcfg_s cur_cfg;
  logic [NUM_CH-1:0] sw_evt_d;
  logic [NUM_CH-1:0] sw_evt_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_q <= '0;
    end else if (srst_w) begin
      sel_q <= '0;
    end else if (ch_wr) begin
      sel_q <= wr_sel;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c] <= ECR_CHCFG_RST;
      end
    end else if (srst_w) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c] <= ECR_CHCFG_RST;
      end
    end else if (ch_wr && ch_full && (int'(wr_sel) < NUM_CH)) begin
      cfg_q[wr_sel] <= wr_cfg;
    end
  end

  always_comb begin
    sw_evt_d = '0;
    if (ch_wr && ch_full && pwdata_in[ECR_CH_SOFTWARE_EVENT_TRIGGER_BIT] && (int'(wr_sel) < NUM_CH)) begin
      sw_evt_d[wr_sel] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_evt_q <= '0;
    end else begin
      sw_evt_q <= sw_evt_d;
    end
  end

  assign cur_cfg = (int'(sel_q) < NUM_CH) ? cfg_q[sel_q] : ECR_CHCFG_RST;

  // ==========================================================
  // user multiplexer setting
  logic [15:0] user_mux_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      user_mux_q <= ECR_USER_RST;
    end else if (srst_w) begin
      user_mux_q <= ECR_USER_RST;
    end else if (wr_en && hit_user) begin
      if (pstrb_in[0]) begin
        user_mux_q[ECR_USER_USR_LSB +: ECR_USER_USR_W] <= pwdata_in[ECR_USER_USR_LSB +: ECR_USER_USR_W];
      end
      if (pstrb_in[1]) begin
        user_mux_q[ECR_USER_CH_LSB +: ECR_USER_CH_W] <= pwdata_in[ECR_USER_CH_LSB +: ECR_USER_CH_W];
      end
    end
  end

  // ==========================================================
  // channels
  ecr_chout_s chan_stat [NUM_CH];
  logic [NUM_CH-1:0] gen_raw;
  logic [NUM_CH-1:0] gen_resync;
  logic [NUM_CH-1:0] ovr_set;
  logic [NUM_CH-1:0] evd_set;
  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0] ready;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    assign gen_raw[c] = (cfg_q[c].gen_sel == '0) ? 1'b0 : gen_events_in[cfg_q[c].gen_sel];

    ecr_sync #(
      .STAGES(ECR_SYNC_STAGES)
    ) u_sync (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .async_in(gen_raw[c]),
      .sync_out(gen_resync[c])
    );

    ecr_channel u_chan (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .soft_rst_in(srst_w),
      .cfg_in(cfg_q[c]),
      .always_on_in(always_on_q),
      .gen_raw_in(gen_raw[c]),
      .gen_resync_in(gen_resync[c]),
      .sw_evt_in(sw_evt_q[c]),
      .users_ready_in(users_ready_in[c]),
      .users_done_in(users_done_in[c]),
      .stat_out(chan_stat[c])
    );

    assign chan_event_out[c] = chan_stat[c].evt;
    assign chan_clk_req_out[c] = chan_stat[c].clk_req;
    assign ovr_set[c] = chan_stat[c].overrun;
    assign evd_set[c] = chan_stat[c].detect;
    assign pending[c] = chan_stat[c].pending;
    assign ready[c] = chan_stat[c].users_ready;
  end

  // ==========================================================
  // interrupt enables and flags
  logic [FL_W-1:0] en_q;
  logic [FL_W-1:0] flags_q;
  logic [FL_W-1:0] set_vec;
  logic [FL_W-1:0] flag_clr;

  assign set_vec = {evd_set, ovr_set};
  assign flag_clr = (wr_en && hit_flags) ? wmask : '0;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q <= '0;
    end else if (srst_w) begin
      en_q <= '0;
    end else if (wr_en && hit_enset) begin
      en_q <= en_q | wmask;
    end else if (wr_en && hit_enclr) begin
      en_q <= en_q & ~wmask;
    end
  end

  // a new event in the clearing cycle keeps its flag
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_q <= '0;
    end else if (srst_w) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | set_vec;
    end
  end

  // one shared level, also the wake source while asleep
  assign irq_out = |(flags_q & en_q);

  // ==========================================================
  // read data
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_chan) begin
      rdata_d[ECR_CH_SEL_LSB +: ECR_CH_SEL_W] = sel_q;
      rdata_d[ECR_CH_GEN_LSB +: ECR_GEN_W] = cur_cfg.gen_sel;
      rdata_d[ECR_CH_PATH_LSB +: 2] = cur_cfg.path;
      rdata_d[ECR_CH_EDGE_LSB +: 2] = cur_cfg.edge_sel;
    end else if (hit_user) begin
      rdata_d[15:0] = user_mux_q;
    end else if (hit_state) begin
      rdata_d = pack_pair({pending, ready});
    end else if (hit_enclr || hit_enset) begin
      rdata_d = pack_pair(en_q);
    end else if (hit_flags) begin
      rdata_d = pack_pair(flags_q);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata_out = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  logic [NUM_CH-1:0] sel_onehot;
  assign sel_onehot = (int'(wr_sel) < NUM_CH) ? NUM_CH'(1) << wr_sel : '0;

  chk_soft_reset: assert property (srst_w |=> en_q == '0 && !always_on_q && sel_q == '0 && !irq_out)
    else $error("soft reset left state behind");
  chk_flag_clear: assert property (wr_en && hit_flags && !srst_w && set_vec == '0
    |=> (flags_q & $past(wmask)) == '0)
    else $error("write one did not clear flag");
  chk_flag_set: assert property (set_vec != '0 && !srst_w
    |=> (flags_q & $past(set_vec)) == $past(set_vec))
    else $error("event did not set its flag");
  chk_enable_set: assert property (wr_en && hit_enset
    |=> (en_q & $past(wmask)) == $past(wmask))
    else $error("enable set failed");
  chk_enable_clear: assert property (wr_en && hit_enclr
    |=> (en_q & $past(wmask)) == '0)
    else $error("enable clear failed");
  chk_irq_hold: assert property (irq_out && !wr_en |=> irq_out)
    else $error("irq dropped without clear or disable");
  chk_irq_shared: assert property ((set_vec & en_q) != '0 && !wr_en |=> irq_out)
    else $error("enabled source missed shared irq");
  chk_software_event_trigger_inject: assert property (ch_wr && ch_full && pwdata_in[ECR_CH_SOFTWARE_EVENT_TRIGGER_BIT]
    |=> sw_evt_q == $past(sel_onehot))
    else $error("software event not on selected channel");
  chk_cfg_readback: assert property (rd_setup && hit_chan
    |=> prdata_out[ECR_CH_GEN_LSB +: ECR_GEN_W] == $past(cur_cfg.gen_sel))
    else $error("config readback mismatch");

  cov_sw_event: cover property (sw_evt_q != '0 ##1 flags_q[FL_W-1:NUM_CH] != '0);
  cov_overrun: cover property (ovr_set != '0);
  cov_irq_rise: cover property ($rose(irq_out));
  cov_soft_reset: cover property (srst_w);

endmodule : ecr_router

// ===== testbench/ecr_users.sv
`timescale 1ns/10ps
module ecr_users
  import ecr_pkg::*;
#(
  parameter int NUM_CH = ECR_NUM_CH
)(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // channel side
  input wire logic [NUM_CH-1:0] event_in,
  input wire logic stall_in,
  output logic [NUM_CH-1:0] users_ready_out,
  output logic [NUM_CH-1:0] users_done_out
);
  // ==========================
  // user busy from event until handled
  logic [NUM_CH-1:0] busy_q;
  logic [NUM_CH-1:0] busy_d;

  // stall keeps users busy, so a slow user is modelled
  assign busy_d = event_in | (busy_q & {NUM_CH{stall_in}});

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_q <= '0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign users_ready_out = ~busy_q;
  assign users_done_out = busy_q & ~{NUM_CH{stall_in}};
endmodule : ecr_users

// ===== testbench/test_event_channel_router.sv
`timescale 1ns/10ps
module test_event_channel_router
  import ecr_pkg::*;
;
  // ==========================
  // signals
  typedef struct packed {
    logic [1:0] path;
    logic [1:0] edg;
    logic [3:0] c1;
    logic [3:0] c2;
    logic [15:0] flags;
  } ecr_row_s;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, stall;
  logic [ECR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [63:0] gen;
  logic [5:0] urdy, udone, chev, clkreq;
  logic ev_prev;
  int bad_count = 0, compares = 0, cycles = 0, ev_cnt = 0, base;
  ecr_row_s rows [8] = '{
    '{ECR_PATH_SYNC, ECR_EDGE_NONE, 4'h0, 4'h0, 16'h0000},
    '{ECR_PATH_SYNC, ECR_EDGE_RISE, 4'h1, 4'h1, 16'h0100},
    '{ECR_PATH_SYNC, ECR_EDGE_FALL, 4'h0, 4'h1, 16'h0100},
    '{ECR_PATH_SYNC, ECR_EDGE_BOTH, 4'h1, 4'h2, 16'h0100},
    '{ECR_PATH_RESYNC, ECR_EDGE_RISE, 4'h1, 4'h1, 16'h0100},
    '{ECR_PATH_RESYNC, ECR_EDGE_FALL, 4'h0, 4'h1, 16'h0100},
    '{ECR_PATH_ASYNC, ECR_EDGE_NONE, 4'h1, 4'h1, 16'h0000},
    '{2'h3, ECR_EDGE_RISE, 4'h0, 4'h0, 16'h0000}
  };

  ecr_router ecr_router_i (.core_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .gen_events_in(gen), .users_ready_in(urdy),
    .users_done_in(udone), .chan_event_out(chev), .chan_clk_req_out(clkreq), .irq_out(irq));
  ecr_users ecr_users_i (.core_clk_in(clk), .arst_n_in(arst_n), .event_in(chev), .stall_in(stall),
    .users_ready_out(urdy), .users_done_out(udone));

  always #20 clk = ~clk;

  // ==========================
  // event counter and timeout
  always @(posedge clk) begin
    ev_prev <= chev[0];
    if (chev[0] === 1'b1 && ev_prev !== 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end

  // ==========================
  // tasks
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic check32(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check32

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, s, rd, err);
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, 4'h0, rd, err);
    check32(exp, rd);
  endtask : chk_reg

  task automatic pulse();
    gen[3] <= 1'b1;
    repeat (6) @(posedge clk);
    gen[3] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  // ==========================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    clk = 1'b0;
    arst_n <= 1'b0;
    {psel, penable, pwrite, stall} <= 4'h0;
    paddr <= '0;
    pwdata <= 32'h0;
    pstrb <= 4'h0;
    gen <= 64'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_reg(ECR_OFS_STATE, 32'h0000003F);
    chk_reg(ECR_OFS_CHAN, 32'h0);
    chk_reg(ECR_OFS_FLAGS, 32'h0);
    end_test("reset");
    foreach (rows[i]) begin
      wr(ECR_OFS_CHAN, {4'h0, rows[i].edg, rows[i].path, 2'h0, 6'h03, 16'h0000}, 4'hF);
      wr(ECR_OFS_FLAGS, 32'h3F3F, 4'hF);
      base = ev_cnt;
      gen[3] <= 1'b1;
      repeat (6) @(posedge clk);
      check32({28'h0, rows[i].c1}, 32'(ev_cnt - base));
      gen[3] <= 1'b0;
      repeat (6) @(posedge clk);
      check32({28'h0, rows[i].c2}, 32'(ev_cnt - base));
      chk_reg(ECR_OFS_FLAGS, {16'h0, rows[i].flags});
    end
    end_test("edges");
    wr(ECR_OFS_CHAN, 32'h04030000, 4'hF);
    wr(ECR_OFS_FLAGS, 32'h3F3F, 4'hF);
    wr(ECR_OFS_ENSET, 32'h0100, 4'hF);
    chk_reg(ECR_OFS_ENSET, 32'h0100);
    pulse();
    check32({31'h0, irq}, 32'h1);
    wr(ECR_OFS_ENCLR, 32'h0100, 4'hF);
    check32({31'h0, irq}, 32'h0);
    wr(ECR_OFS_ENSET, 32'h0100, 4'hF);
    check32({31'h0, irq}, 32'h1);
    wr(ECR_OFS_FLAGS, 32'h0100, 4'hF);
    check32({31'h0, irq}, 32'h0);
    chk_reg(ECR_OFS_FLAGS, 32'h0);
    end_test("irq");
    stall <= 1'b1;
    pulse();
    chk_reg(ECR_OFS_STATE, 32'h0000013E);
    pulse();
    chk_reg(ECR_OFS_FLAGS, 32'h0101);
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg(ECR_OFS_STATE, 32'h0000003F);
    end_test("overrun");
    check32({26'h0, clkreq}, 32'h0);
    wr(ECR_OFS_CTRL, 32'h10, 4'h1);
    check32({26'h0, clkreq}, 32'h3F);
    wr(ECR_OFS_FLAGS, 32'h3F3F, 4'hF);
    wr(ECR_OFS_CHAN, 32'h04030100, 4'hF);
    repeat (4) @(posedge clk);
    chk_reg(ECR_OFS_FLAGS, 32'h0100);
    end_test("software event");
    wr(ECR_OFS_CHAN, 32'h08050001, 4'hF);
    wr(ECR_OFS_CHAN, 32'h0, 4'h1);
    chk_reg(ECR_OFS_CHAN, 32'h04030000);
    wr(ECR_OFS_CHAN, 32'h1, 4'h1);
    chk_reg(ECR_OFS_CHAN, 32'h08050001);
    end_test("readback");
    wr(ECR_OFS_USER, 32'h0000051F, 4'h3);
    chk_reg(ECR_OFS_USER, 32'h0000051F);
    wr(ECR_OFS_CTRL, 32'h11, 4'h1);
    chk_reg(ECR_OFS_USER, 32'h0);
    chk_reg(ECR_OFS_ENSET, 32'h0);
    chk_reg(ECR_OFS_CHAN, 32'h0);
    check32({26'h0, clkreq}, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 4'h0, rd, err);
    check32({31'h0, err}, 32'h1);
    check32(32'h0, rd);
    end_test("soft reset and unmapped");
    close_out();
  end
endmodule : test_event_channel_router
